// ### rtl/mode_pin_config_latch.sv
// strap capture, mode decode and live power control of the flex port
`timescale 1ns/1ns
`default_nettype none
module mode_pin_config_latch #(
  parameter int WARMUP_CYCLES = strap_cfg_pkg::FAST_POWERUP_CYCLES,
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // straps and live control pins from the board and back end
  input wire logic serial_select_pin,
  input wire logic serial_bidir_data_pin_in,
  output logic serial_bidir_data_pin_out,
  output logic serial_bidir_data_pin_oe,
  input wire logic serial_clock_pin,
  input wire logic serial_out_pin_in,
  output logic serial_out_pin_out,
  output logic serial_out_pin_oe,
  input wire logic flex_port_pin_one,
  input wire logic flex_port_pin_two,
  input wire logic adc_low_power_strap,
  input wire logic receive_powerdown_pin,
  input wire logic transmit_powerdown_pin,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  // resulting configuration
  output logic config_valid,
  output logic serial_port_enable,
  output strap_cfg_pkg::flex_mode_e flex_mode,
  output logic [1:0] interp_factor,
  output logic [1:0] pll_factor,
  output logic adc_low_power,
  output logic pll_run,
  // receive path controls
  output logic receive_digital_clk_en,
  output logic adc_clk_en,
  output logic receive_fast_analog_off,
  output logic receive_ready,
  // transmit path controls
  output logic transmit_digital_clk_en,
  output logic dac_clk_en,
  output logic transmit_fast_analog_off,
  output logic transmit_ready,
  // data bus direction, high while the device drives that half
  output logic upper_bus_drive,
  output logic lower_bus_drive
);

  // register widths below eight bits cannot hold the fields
  if (DATA_W < 8 || ADDR_W < 8) begin : g_bad_bus
    $error("mode_pin_config_latch: ADDR_W and DATA_W must be >= 8");
  end

  // ------------------------------------------------------------------
  // strap capture
  // ------------------------------------------------------------------

  logic [strap_cfg_pkg::STRAP_W-1:0] strap_levels; // raw pins, gathered
  logic [strap_cfg_pkg::STRAP_W-1:0] straps; // held after release
  logic straps_valid; // high from the first edge after release

  // the serial pins double as strap inputs, see capture below
  assign strap_levels[strap_cfg_pkg::STRAP_SELECT_BIT] = serial_select_pin;
  assign strap_levels[strap_cfg_pkg::STRAP_DUPLEX_BIT] = serial_out_pin_in;
  assign strap_levels[strap_cfg_pkg::STRAP_WIDTH_BIT] = flex_port_pin_two;
  assign strap_levels[strap_cfg_pkg::STRAP_INTERP_HI_BIT] =
    serial_bidir_data_pin_in;
  assign strap_levels[strap_cfg_pkg::STRAP_INTERP_LO_BIT] = serial_clock_pin;
  assign strap_levels[strap_cfg_pkg::STRAP_LOW_POWER_BIT] =
    adc_low_power_strap;

  // one capture per reset; later pin changes never reach straps
  strap_latch #(
    .WIDTH(strap_cfg_pkg::STRAP_W)
  ) u_strap_latch (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .strap_in(strap_levels),
    .captured(straps),
    .valid(straps_valid)
  );

  // named views of the held straps
  wire serial_on = straps[strap_cfg_pkg::STRAP_SELECT_BIT];
  wire strap_duplex = straps[strap_cfg_pkg::STRAP_DUPLEX_BIT];
  wire strap_width = straps[strap_cfg_pkg::STRAP_WIDTH_BIT];
  wire [1:0] strap_interp = {straps[strap_cfg_pkg::STRAP_INTERP_HI_BIT],
                             straps[strap_cfg_pkg::STRAP_INTERP_LO_BIT]};
  wire strap_low_power = straps[strap_cfg_pkg::STRAP_LOW_POWER_BIT];

  // serial pins stay released: in strap mode they are inputs, and the
  // serial protocol engine that would drive them lives elsewhere
  assign serial_bidir_data_pin_out = 1'b0;
  assign serial_bidir_data_pin_oe = 1'b1;
  assign serial_out_pin_out = 1'b0;
  assign serial_out_pin_oe = 1'b1;

  // ------------------------------------------------------------------
  // register port
  // ------------------------------------------------------------------

  logic [7:0] control; // software settings, used with serial port on

  // decode with named wires
  wire hit_control = (reg_addr == ADDR_W'(strap_cfg_pkg::CONTROL_OFFSET));
  wire hit_status = (reg_addr == ADDR_W'(strap_cfg_pkg::STATUS_OFFSET));
  wire hit_live = (reg_addr == ADDR_W'(strap_cfg_pkg::LIVE_OFFSET));

  // writes only land once the serial port came up enabled; with the
  // port disabled it is unusable until the next reset
  wire control_we = reg_write && hit_control && straps_valid &&
                    serial_on;

  // control register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      control <= strap_cfg_pkg::CONTROL_RESET;
    end else if (clk_en && control_we) begin
      control <= reg_wdata[7:0] & strap_cfg_pkg::CONTROL_WRITE_MASK;
    end
  end

  // named views of the control register
  wire sw_pll_off = control[strap_cfg_pkg::CTRL_PLL_OFF_BIT];
  wire sw_full_duplex = control[strap_cfg_pkg::CTRL_FULL_DUPLEX_BIT];
  wire sw_interleaved = control[strap_cfg_pkg::CTRL_INTERLEAVED_BIT];
  wire [1:0] sw_interp = {control[strap_cfg_pkg::CTRL_INTERP_HI_BIT],
                          control[strap_cfg_pkg::CTRL_INTERP_LO_BIT]};

  // ------------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------------

  // settings the registers replace come from control, else straps
  wire use_full_duplex = serial_on ? sw_full_duplex : strap_duplex;
  wire use_interleaved = serial_on ? sw_interleaved : strap_width;
  wire [1:0] use_interp = serial_on ? sw_interp : strap_interp;

  strap_cfg_pkg::flex_mode_e next_mode; // decoded interface mode
  logic [1:0] next_interp; // decoded factor

  // duplex first, then bus width only matters in half duplex
  always_comb begin
    if (use_full_duplex) begin
      next_mode = strap_cfg_pkg::full_duplex_mode;
    end else if (use_interleaved) begin
      next_mode = strap_cfg_pkg::half_duplex_interleaved_mode;
    end else begin
      next_mode = strap_cfg_pkg::half_duplex_parallel_mode;
    end
  end

  // factor decode; the unused code 11 falls back to 1x
  always_comb begin
    case (use_interp)
      strap_cfg_pkg::INTERP_2X: next_interp = strap_cfg_pkg::INTERP_2X;
      strap_cfg_pkg::INTERP_4X: next_interp = strap_cfg_pkg::INTERP_4X;
      default: next_interp = strap_cfg_pkg::INTERP_1X;
    endcase
  end

  // configuration outputs, frozen in strap mode since straps are held
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      config_valid <= 1'b0;
      serial_port_enable <= 1'b0;
      flex_mode <= strap_cfg_pkg::half_duplex_parallel_mode;
      interp_factor <= strap_cfg_pkg::INTERP_1X;
      pll_factor <= strap_cfg_pkg::INTERP_1X;
      adc_low_power <= 1'b0;
      pll_run <= 1'b0;
    end else if (clk_en) begin
      config_valid <= straps_valid;
      serial_port_enable <= straps_valid && serial_on;
      flex_mode <= next_mode;
      interp_factor <= next_interp;
      pll_factor <= next_interp;
      adc_low_power <= strap_low_power;
      // pll ignores transmit power-down; only software stops it
      pll_run <= straps_valid && !sw_pll_off;
    end
  end

  // ------------------------------------------------------------------
  // live path selection and power control
  // ------------------------------------------------------------------

  wire half_duplex = (next_mode != strap_cfg_pkg::full_duplex_mode);
  // path pin high means transmit; polarity needs confirming
  wire transmit_selected = flex_port_pin_one;
  // in full duplex the pin has no path effect at all
  wire receive_deselected = half_duplex && transmit_selected;
  wire transmit_deselected = half_duplex && !transmit_selected;

  // receive path: adc clock and fast bias follow the pin each cycle
  path_power_gate #(
    .WARMUP_CYCLES(WARMUP_CYCLES)
  ) u_receive_gate (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .config_valid(straps_valid),
    .powerdown(receive_powerdown_pin),
    .deselected(receive_deselected),
    .digital_clk_en(receive_digital_clk_en),
    .converter_clk_en(adc_clk_en),
    .fast_analog_off(receive_fast_analog_off),
    .path_ready(receive_ready)
  );

  // transmit path: dac clocks and fast bias follow the pin each cycle
  path_power_gate #(
    .WARMUP_CYCLES(WARMUP_CYCLES)
  ) u_transmit_gate (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .config_valid(straps_valid),
    .powerdown(transmit_powerdown_pin),
    .deselected(transmit_deselected),
    .digital_clk_en(transmit_digital_clk_en),
    .converter_clk_en(dac_clk_en),
    .fast_analog_off(transmit_fast_analog_off),
    .path_ready(transmit_ready)
  );

  // bus direction per mode
  logic next_upper_drive;
  logic next_lower_drive;

  // full duplex: upper takes transmit data, lower carries receive.
  // half duplex transmit: both halves are inputs. half duplex receive:
  // both drive in parallel mode, only lower in interleaved mode so the
  // two halves can be tied together on the board
  always_comb begin
    if (!straps_valid) begin
      next_upper_drive = 1'b0;
      next_lower_drive = 1'b0;
    end else if (!half_duplex) begin
      next_upper_drive = 1'b0;
      next_lower_drive = 1'b1;
    end else if (transmit_selected) begin
      next_upper_drive = 1'b0;
      next_lower_drive = 1'b0;
    end else begin
      next_upper_drive = !use_interleaved;
      next_lower_drive = 1'b1;
    end
  end

  // registered so the bus enables never glitch
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      upper_bus_drive <= 1'b0;
      lower_bus_drive <= 1'b0;
    end else if (clk_en) begin
      upper_bus_drive <= next_upper_drive;
      lower_bus_drive <= next_lower_drive;
    end
  end

  // ------------------------------------------------------------------
  // read back
  // ------------------------------------------------------------------

  // held straps, plus whether they are valid yet
  wire [7:0] status_word = {1'b0, straps_valid, straps};
  // live pins and path state
  wire [7:0] live_word = {receive_ready, transmit_ready,
                          flex_port_pin_one, receive_powerdown_pin,
                          transmit_powerdown_pin, pll_run,
                          upper_bus_drive, lower_bus_drive};

  wire [7:0] read_word = hit_control ? control :
                         hit_status ? status_word :
                         hit_live ? live_word : 8'h00;

  // read data stand the cycle after the strobe only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= reg_read ? DATA_W'(read_word) : '0;
    end
  end

endmodule
`default_nettype wire

// ### rtl/path_power_gate.sv
// power and clock gating for one converter path, with warm-up timer
`timescale 1ns/1ns
`default_nettype none
module path_power_gate #(
  parameter int WARMUP_CYCLES = strap_cfg_pkg::FAST_POWERUP_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic config_valid,
  input wire logic powerdown,
  input wire logic deselected,
  output logic digital_clk_en,
  output logic converter_clk_en,
  output logic fast_analog_off,
  output logic path_ready
);

  localparam int CW = $clog2(WARMUP_CYCLES + 1);

  // a zero count would make the ready flag meaningless
  if (WARMUP_CYCLES < 1) begin : g_bad_warmup
    $error("path_power_gate: WARMUP_CYCLES must be at least 1");
  end

  logic [CW-1:0] warm_count; // cycles since the analog side woke
  wire warm_done = (warm_count == CW'(WARMUP_CYCLES));

  // power-down pin acts on every cycle, not only at reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      digital_clk_en <= 1'b0;
      converter_clk_en <= 1'b0;
      fast_analog_off <= 1'b1;
      warm_count <= '0;
      path_ready <= 1'b0;
    end else if (clk_en) begin
      // deselect gates digital clocks only, analog stays up
      digital_clk_en <= config_valid && !powerdown && !deselected;
      converter_clk_en <= config_valid && !powerdown;
      fast_analog_off <= !config_valid || powerdown;
      // restart the warm-up count whenever analog goes down
      if (!config_valid || powerdown) begin
        warm_count <= '0;
      end else if (!warm_done) begin
        warm_count <= warm_count + CW'(1);
      end
      path_ready <= warm_done && config_valid && !powerdown;
    end
  end

endmodule
`default_nettype wire

// ### rtl/strap_cfg_pkg.sv
// constants shared by the strap latch and power gating logic
package strap_cfg_pkg;

  // register offsets on the plain register port
  localparam logic [7:0] CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h01;
  localparam logic [7:0] LIVE_OFFSET = 8'h02;

  // control register fields (used only with the serial port enabled)
  localparam int CTRL_PLL_OFF_BIT = 0;
  localparam int CTRL_FULL_DUPLEX_BIT = 1;
  localparam int CTRL_INTERLEAVED_BIT = 2;
  localparam int CTRL_INTERP_LO_BIT = 3;
  localparam int CTRL_INTERP_HI_BIT = 4;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'h1f;

  // positions inside the captured strap vector
  localparam int STRAP_W = 6;
  localparam int STRAP_LOW_POWER_BIT = 0;
  localparam int STRAP_INTERP_LO_BIT = 1;
  localparam int STRAP_INTERP_HI_BIT = 2;
  localparam int STRAP_WIDTH_BIT = 3;
  localparam int STRAP_DUPLEX_BIT = 4;
  localparam int STRAP_SELECT_BIT = 5;
  localparam logic [STRAP_W-1:0] STRAP_RESET = 6'h00;

  // interpolation and pll factor codes
  localparam logic [1:0] INTERP_1X = 2'h0;
  localparam logic [1:0] INTERP_2X = 2'h1;
  localparam logic [1:0] INTERP_4X = 2'h2;

  // analog blocks that restart faster than this are switched off
  localparam int FAST_POWERUP_US = 10;
  localparam int REF_CLK_MHZ = 25;
  localparam int FAST_POWERUP_CYCLES = FAST_POWERUP_US * REF_CLK_MHZ;

  // flexible interface operating modes
  typedef enum logic [1:0] {
    full_duplex_mode,
    half_duplex_parallel_mode,
    half_duplex_interleaved_mode
  } flex_mode_e;

endpackage

// ### rtl/strap_latch.sv
// one-shot capture of strap levels at the first edge after reset release
`timescale 1ns/1ns
`default_nettype none
module strap_latch #(
  parameter int WIDTH = 6
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] strap_in,
  output logic [WIDTH-1:0] captured,
  output logic valid
);

  // refuse a zero-width strap vector
  if (WIDTH < 1) begin : g_bad_width
    $error("strap_latch: WIDTH must be at least 1");
  end

  // async reset loads constants only; levels are caught by the clock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      captured <= '0;
      valid <= 1'b0;
    end else if (clk_en && !valid) begin
      captured <= strap_in;
      valid <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ### testbench/mode_pin_config_latch_chk.sv
// checker for captured configuration and live power gating
`timescale 1ns/1ns
`default_nettype none
module mode_pin_config_latch_chk #(
  parameter int WARMUP_CYCLES = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic serial_bidir_data_pin_oe,
  input wire logic serial_out_pin_oe,
  input wire logic flex_port_pin_one,
  input wire logic receive_powerdown_pin,
  input wire logic transmit_powerdown_pin,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic config_valid,
  input wire logic serial_port_enable,
  input wire strap_cfg_pkg::flex_mode_e flex_mode,
  input wire logic [1:0] interp_factor,
  input wire logic [1:0] pll_factor,
  input wire logic adc_low_power,
  input wire logic pll_run,
  input wire logic receive_digital_clk_en,
  input wire logic adc_clk_en,
  input wire logic receive_fast_analog_off,
  input wire logic receive_ready,
  input wire logic transmit_digital_clk_en,
  input wire logic dac_clk_en,
  input wire logic transmit_fast_analog_off,
  input wire logic transmit_ready,
  input wire logic upper_bus_drive,
  input wire logic lower_bus_drive
);
  // margin of two edges: capture flag leads config_valid by one
  localparam int MIN_WARM = WARMUP_CYCLES - 2;
  logic [15:0] warm_cnt; // configured edges with receive path powered
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // restart the count whenever the receive path is powered down
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) warm_cnt <= 16'h0;
    else if (clk_en) warm_cnt <= receive_powerdown_pin ? 16'h0 :
      (config_valid ? warm_cnt + 16'h1 : 16'h0);
  end
  // a read outside the map
  sequence unmapped_read;
    clk_en && reg_read && reg_addr > strap_cfg_pkg::LIVE_OFFSET;
  endsequence
  // configured half duplex with no mode change under way; the registered
  // mode lags a control write by one edge while the gating already moved
  sequence half_live;
    clk_en && config_valid && !reg_write && !$past(reg_write) &&
      !receive_powerdown_pin &&
      flex_mode != strap_cfg_pkg::full_duplex_mode;
  endsequence
  a_pins_released: assert property (
    serial_bidir_data_pin_oe && serial_out_pin_oe)
    else $error("serial strap pins driven by device");
  a_rx_pd_gates: assert property (
    clk_en && receive_powerdown_pin |=> !adc_clk_en &&
      !receive_digital_clk_en && receive_fast_analog_off && !receive_ready)
    else $error("receive power-down not applied");
  a_tx_pd_gates: assert property (
    clk_en && transmit_powerdown_pin |=> !dac_clk_en &&
      !transmit_digital_clk_en && transmit_fast_analog_off && !transmit_ready)
    else $error("transmit power-down not applied");
  a_pll_kept: assert property (
    clk_en && !reg_write && pll_run && transmit_powerdown_pin |=> pll_run)
    else $error("pll stopped by transmit power-down");
  a_rx_selected: assert property (
    half_live ##0 !flex_port_pin_one |=>
      !transmit_digital_clk_en && lower_bus_drive)
    else $error("receive selection wrong");
  a_tx_selected: assert property (
    half_live ##0 (flex_port_pin_one && !transmit_powerdown_pin) |=>
      !receive_digital_clk_en && adc_clk_en && transmit_digital_clk_en &&
      !upper_bus_drive && !lower_bus_drive)
    else $error("transmit selection wrong");
  a_full_ignores_path: assert property (
    clk_en && config_valid && !reg_write && !receive_powerdown_pin &&
      flex_mode == strap_cfg_pkg::full_duplex_mode |=>
      !upper_bus_drive && lower_bus_drive)
    else $error("full duplex bus direction wrong");
  a_straps_held: assert property (
    config_valid && !serial_port_enable |=> $stable(flex_mode) &&
      $stable(interp_factor) && $stable(adc_low_power))
    else $error("latched configuration changed");
  a_pll_factor_same: assert property (
    config_valid |-> pll_factor == interp_factor)
    else $error("pll factor differs from interpolation");
  a_unmapped_zero: assert property (
    unmapped_read |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_one_cycle: assert property (
    clk_en && !reg_read |=> reg_rdata == 8'h00)
    else $error("read data held too long");
  a_ready_waits: assert property (
    receive_ready |-> warm_cnt >= MIN_WARM)
    else $error("receive ready before warm-up");
endmodule
bind mode_pin_config_latch mode_pin_config_latch_chk #(
  .WARMUP_CYCLES(WARMUP_CYCLES)
) u_chk (.*);
`default_nettype wire

// ### testbench/strap_board.sv
// board straps and back-end live pins facing the strap latch
`timescale 1ns/1ns
`default_nettype none
module strap_board (
  input wire logic [5:0] straps,
  input wire logic path_tx,
  input wire logic rx_off,
  input wire logic tx_off,
  input wire logic serial_bidir_data_pin_out,
  input wire logic serial_bidir_data_pin_oe,
  input wire logic serial_out_pin_out,
  input wire logic serial_out_pin_oe,
  output logic serial_select_pin,
  output logic serial_bidir_data_pin_in,
  output logic serial_clock_pin,
  output logic serial_out_pin_in,
  output logic flex_port_pin_one,
  output logic flex_port_pin_two,
  output logic adc_low_power_strap,
  output logic receive_powerdown_pin,
  output logic transmit_powerdown_pin
);
  // select is a fixed resistor, so it holds through and after reset
  assign serial_select_pin = straps[5];
  // shared pins: device wins while its enable is low, else the strap
  assign serial_bidir_data_pin_in =
    serial_bidir_data_pin_oe ? straps[2] : serial_bidir_data_pin_out;
  assign serial_out_pin_in =
    serial_out_pin_oe ? straps[4] : serial_out_pin_out;
  assign serial_clock_pin = straps[1]; // low interpolation strap
  assign flex_port_pin_two = straps[3]; // bus width strap
  assign adc_low_power_strap = straps[0]; // adc power strap
  // live levels from the back end, changed at any time
  assign flex_port_pin_one = path_tx;
  assign receive_powerdown_pin = rx_off;
  assign transmit_powerdown_pin = tx_off;
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the strap latch and live power pins
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct {
    logic [5:0] s; // select, duplex, width, interp hi, interp lo, low power
    strap_cfg_pkg::flex_mode_e m; // expected mode
    logic [1:0] f; // expected interpolation code
    logic lp; // expected adc low power
    logic spe; // expected serial port enable
  } row_s;
  logic ref_clk, rst, clk_en, reg_write, reg_read;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
  logic [5:0] straps;
  logic path_tx, rx_off, tx_off;
  logic serial_select_pin, serial_bidir_data_pin_in;
  logic serial_bidir_data_pin_out, serial_bidir_data_pin_oe;
  logic serial_clock_pin, serial_out_pin_in, serial_out_pin_out;
  logic serial_out_pin_oe, flex_port_pin_one, flex_port_pin_two;
  logic adc_low_power_strap, receive_powerdown_pin, transmit_powerdown_pin;
  logic config_valid, serial_port_enable, adc_low_power, pll_run;
  strap_cfg_pkg::flex_mode_e flex_mode;
  logic [1:0] interp_factor, pll_factor;
  logic receive_digital_clk_en, adc_clk_en, receive_fast_analog_off;
  logic receive_ready, transmit_digital_clk_en, dac_clk_en;
  logic transmit_fast_analog_off, transmit_ready;
  logic upper_bus_drive, lower_bus_drive;
  int n_errors, total_checks;
  // strap sets and the configuration each should give
  row_s rows [5] = '{
    '{6'h00, strap_cfg_pkg::half_duplex_parallel_mode, 2'h0, 1'b0, 1'b0},
    '{6'h0b, strap_cfg_pkg::half_duplex_interleaved_mode, 2'h1, 1'b1, 1'b0},
    '{6'h14, strap_cfg_pkg::full_duplex_mode, 2'h2, 1'b0, 1'b0},
    '{6'h17, strap_cfg_pkg::full_duplex_mode, 2'h0, 1'b1, 1'b0},
    '{6'h3e, strap_cfg_pkg::half_duplex_parallel_mode, 2'h0, 1'b0, 1'b1}};
  // short warm-up keeps the ready checks quick
  mode_pin_config_latch #(.WARMUP_CYCLES(4)) dut (.*);
  strap_board board (.*);
  always #20 ref_clk = ~ref_clk;
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one comparison, unknowns match only unknowns
  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // full reset with a strap set on the pins
  task automatic boot(input logic [5:0] s);
    rst <= 1'b1;
    straps <= s;
    tick(6);
    rst <= 1'b0;
    tick(4);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    tick(1);
    reg_write <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    tick(1);
    reg_read <= 1'b0;
    // take the data mid-cycle, while they settle and stand
    @(negedge ref_clk);
    d = reg_rdata;
    tick(1);
  endtask
  // set live pins, then give them two edges to act
  task automatic live(input logic p, input logic r, input logic t);
    path_tx <= p;
    rx_off <= r;
    tx_off <= t;
    tick(2);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // watchdog well past the expected run of under two hundred cycles
  initial begin
    tick(3000);
    n_errors++;
    final_report();
  end
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    clk_en = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    straps = 6'h00;
    path_tx = 1'b0;
    rx_off = 1'b0;
    tx_off = 1'b0;
    // each row: capture, then flip every strap but select and expect no change
    foreach (rows[i]) begin
      boot(rows[i].s);
      repeat (2) begin
        check(8'(flex_mode), 8'(rows[i].m), "mode");
        check(8'(interp_factor), 8'(rows[i].f), "interp");
        check(8'(pll_factor), 8'(rows[i].f), "pll");
        check(8'(adc_low_power), 8'(rows[i].lp), "low power");
        check(8'(serial_port_enable), 8'(rows[i].spe), "spe");
        straps <= rows[i].s ^ 6'h1f;
        tick(3);
      end
    end
    // serial port enabled: control register takes over
    reg_wr(strap_cfg_pkg::CONTROL_OFFSET, 8'h12);
    tick(2);
    check(8'(flex_mode), 8'h0, "reg mode");
    check(8'(interp_factor), 8'h2, "reg interp");
    reg_wr(strap_cfg_pkg::CONTROL_OFFSET, 8'hff);
    reg_rd(strap_cfg_pkg::CONTROL_OFFSET, rd);
    check(rd, 8'h1f, "control mask");
    tick(1);
    check(8'(pll_run), 8'h0, "pll off");
    reg_wr(strap_cfg_pkg::STATUS_OFFSET, 8'h00);
    reg_rd(strap_cfg_pkg::STATUS_OFFSET, rd);
    check(rd, 8'h7e, "status");
    reg_rd(8'h7f, rd);
    check(rd, 8'h00, "unmapped");
    // reset in mid-run
    rst <= 1'b1;
    tick(2);
    check(8'(config_valid), 8'h0, "reset valid");
    check(8'(receive_fast_analog_off), 8'h1, "reset analog");
    // strap mode, half parallel: writes refused, live pins
    boot(6'h00);
    reg_wr(strap_cfg_pkg::CONTROL_OFFSET, 8'h12);
    tick(2);
    check(8'(flex_mode), 8'h1, "refused write");
    live(1'b0, 1'b0, 1'b0);
    check({3'h0, transmit_digital_clk_en, receive_digital_clk_en, adc_clk_en,
           upper_bus_drive, lower_bus_drive}, 8'h0f, "rx path");
    live(1'b1, 1'b0, 1'b0);
    check({3'h0, transmit_digital_clk_en, receive_digital_clk_en, adc_clk_en,
           upper_bus_drive, lower_bus_drive}, 8'h14, "tx path");
    live(1'b1, 1'b1, 1'b0);
    check({5'h0, adc_clk_en, receive_fast_analog_off, receive_ready},
          8'h02, "rx off");
    live(1'b1, 1'b0, 1'b0);
    check(8'(receive_ready), 8'h0, "warming");
    tick(8);
    check(8'(receive_ready), 8'h1, "ready");
    live(1'b0, 1'b0, 1'b1);
    check({4'h0, dac_clk_en, transmit_fast_analog_off, transmit_ready,
           pll_run}, 8'h05, "tx off");
    // frozen clock enable holds every output
    clk_en <= 1'b0;
    live(1'b0, 1'b1, 1'b0);
    check(8'(adc_clk_en), 8'h1, "frozen");
    clk_en <= 1'b1;
    tick(2);
    check(8'(adc_clk_en), 8'h0, "unfrozen");
    // interleaved: only the lower half drives
    boot(6'h0b);
    live(1'b0, 1'b0, 1'b0);
    check({6'h0, upper_bus_drive, lower_bus_drive}, 8'h01, "half_duplex_interleaved_mode");
    // full duplex ignores the path pin
    boot(6'h14);
    for (int p = 0; p < 2; p++) begin
      live(p[0], 1'b0, 1'b0);
      check({4'h0, transmit_digital_clk_en, receive_digital_clk_en,
             upper_bus_drive, lower_bus_drive}, 8'h0d, "fd");
    end
    final_report();
  end
endmodule
`default_nettype wire
